// ==== logic/agc_loop_gain_and_sync.sv ====
// Summary of operation
// - near gain below threshold, far gain above
// - second order loop, poles at one and pole
// - gains and pole are code over 256
// - threshold: 4-bit exponent, 8-bit mantissa
// - loop works in log2, gain is exponent
// - gain applied as fine multiply then shift
// - initial gain used until loop updates
// - 19-bit products feed the power calculation
// - output width selectable, outputs clipped to it
// - mode bit one selects clipping level mode
// - clipping mode uses pre minus post error
// - clipping level comes from desired level
// - channel sync selected when select bit set
// - else one of four pins chosen
// - sync now bit always delivers a sync
// - gain word constant between period and sync updates
// - signal mode power is i squared plus q squared
// - sync loads hold-off, fires at one
// - gain updates once per decimation period
// - desired level: 2-bit exponent, 6-bit mantissa
module agc_loop_gain_and_sync import agc_pkg::*; (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic clk_en,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic signed [IN_W-1:0] in_i,
    input wire logic signed [IN_W-1:0] in_q,
    output logic out_valid,
    input wire logic out_ready,
    output logic [OUT_W-1:0] out_i,
    output logic [OUT_W-1:0] out_q,
    output logic [GAIN_W-1:0] out_gain,
    output logic [GAIN_W-1:0] gain_word,
    input wire logic chan_sync,
    input wire logic [3:0] sync_pin,
    input wire logic sync_now,
    input wire logic chan_sync_sel,
    input wire logic [1:0] sync_pin_sel,
    input wire logic clip_mode,
    input wire logic [2:0] out_width_sel,
    input wire logic [COEF_W-1:0] loop_gain_near,
    input wire logic [COEF_W-1:0] loop_gain_far,
    input wire logic [COEF_W-1:0] loop_pole_location,
    input wire logic [GAIN_W-1:0] error_threshold_level,
    input wire logic [GAIN_W-1:0] initial_signal_gain,
    input wire logic [LVL_W-1:0] desired_level,
    input wire logic [HOLD_W-1:0] holdoff_count,
    input wire logic [DECIM_W-1:0] update_decim
);
    logic [3:0] pin_s1_q, pin_s2_q, pin_s3_q, pin_lvl_q;
    logic pin_rise, sync_req, sync_fire, hold_run_q;
    logic [HOLD_W-1:0] hold_cnt_q;
    logic [DECIM_W-1:0] dec_cnt_q;
    logic [ACC_W-1:0] acc_q, acc_sum;
    logic period_end, upd_ev, in_fire, started_q;
    logic [GAIN_W-1:0] gain_q;
    logic signed [Y_W-1:0] y1_q, y2_q, y_new;
    logic signed [ERR_W-1:0] e1_q, err_now, abs_e1, rms_rel;
    logic [COEF_W-1:0] k_sel;
    logic signed [SCALED_W-1:0] pre_i, pre_q;
    logic signed [OUT_W-1:0] post_i, post_q;
    logic signed [SCALED_W:0] pwr_a, pwr_b;
    logic [ERR_W-1:0] req_mag;
    logic [WORD_W-1:0] buf_data;

    // clip a wide product into the 19-bit scaled range
    function automatic logic signed [SCALED_W-1:0] sat19(
        input logic signed [41:0] v
    );
        if (v > 42'sh3ffff) begin
            return 19'sh3ffff;
        end else if (v < -42'sh40000) begin
            return 19'sh40000;
        end
        return v[SCALED_W-1:0];
    endfunction

    // mantissa multiply by (256 + m), then exponent shift and divide by 256
    function automatic logic signed [SCALED_W-1:0] apply_gain(
        input logic signed [IN_W-1:0] x,
        input logic [GAIN_W-1:0] g
    );
        logic signed [41:0] p;
        p = 42'(x) * $signed(42'({2'b01, g[GAIN_EXP_LSB-1:0]}));
        p = p <<< g[GAIN_W-1:GAIN_EXP_LSB];
        p = p >>> LOG_FRAC;
        return sat19(p);
    endfunction

    // clip to the selected width, result left-justified in 16 bits
    function automatic logic signed [OUT_W-1:0] clip_lj(
        input logic signed [SCALED_W-1:0] v,
        input logic [2:0] sel
    );
        logic [4:0] w;
        logic [4:0] sh;
        logic signed [SCALED_W-1:0] t;
        logic signed [SCALED_W-1:0] lim;
        w = WIDTH_LUT[sel];
        sh = 5'(OUT_W) - w;
        t = v >>> sh;
        lim = (19'sh1 <<< (w - 5'h01)) - 19'sh1;
        if (t > lim) begin
            t = lim;
        end else if (t < -lim - 19'sh1) begin
            t = -lim - 19'sh1;
        end
        t = t <<< sh;
        return t[OUT_W-1:0];
    endfunction

    // complex squared magnitude of one sample pair
    function automatic logic [32:0] power_of(
        input logic signed [SCALED_W:0] a,
        input logic signed [SCALED_W:0] b
    );
        logic signed [15:0] ra;
        logic signed [15:0] rb;
        logic signed [31:0] sa;
        logic signed [31:0] sb;
        ra = 16'(a >>> PWR_SHIFT);
        rb = 16'(b >>> PWR_SHIFT);
        sa = 32'(ra) * 32'(ra);
        sb = 32'(rb) * 32'(rb);
        return 33'($unsigned(sa)) + 33'($unsigned(sb));
    endfunction

    // base-2 log: leading one position plus 8 mantissa bits
    function automatic logic [LOG_W-1:0] log2_q8(input logic [ACC_W-1:0] v);
        logic [5:0] pos;
        logic [ACC_W-1:0] n;
        pos = 6'h00;
        for (int b = 0; b < ACC_W; b++) begin
            if (v[b]) begin
                pos = 6'(b);
            end
        end
        n = v << (6'h2c - pos);
        return {pos, n[ACC_W-2:ACC_W-9]};
    endfunction

    // sync pins: three stages, level taken when stages two and three agree
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            pin_s1_q <= 4'h0;
            pin_s2_q <= 4'h0;
            pin_s3_q <= 4'h0;
            pin_lvl_q <= 4'h0;
        end else if (clk_en) begin
            pin_s1_q <= sync_pin;
            pin_s2_q <= pin_s1_q;
            pin_s3_q <= pin_s2_q;
            for (int b = 0; b < 4; b++) begin
                if (pin_s2_q[b] == pin_s3_q[b]) begin
                    pin_lvl_q[b] <= pin_s3_q[b];
                end
            end
        end
    end

    // sync source select plus the software sync
    assign pin_rise = pin_s2_q[sync_pin_sel] && pin_s3_q[sync_pin_sel]
        && !pin_lvl_q[sync_pin_sel];
    assign sync_req = clk_en && (sync_now
        || (chan_sync_sel ? chan_sync : pin_rise));

    // sample handshake and period bookkeeping
    assign in_fire = in_valid && in_ready && clk_en;
    assign sync_fire = hold_run_q && in_fire
        && (hold_cnt_q <= HOLD_FIRE);
    assign period_end = in_fire && (dec_cnt_q == update_decim);
    assign upd_ev = period_end || sync_fire;

    // hold-off counter, loaded by each sync, counts input samples
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            hold_cnt_q <= 16'h0000;
            hold_run_q <= 1'b0;
        end else if (clk_en) begin
            if (sync_req) begin
                hold_cnt_q <= holdoff_count;
                hold_run_q <= 1'b1;
            end else if (sync_fire) begin
                hold_run_q <= 1'b0;
            end else if (hold_run_q && in_fire) begin
                hold_cnt_q <= hold_cnt_q - 16'h0001;
            end
        end
    end

    // gain multiplier, clipping and the power source
    always_comb begin
        pre_i = apply_gain(in_i, gain_q);
        pre_q = apply_gain(in_q, gain_q);
        post_i = clip_lj(pre_i, out_width_sel);
        post_q = clip_lj(pre_q, out_width_sel);
        if (clip_mode) begin
            pwr_a = 20'(pre_i) - 20'(post_i);
            pwr_b = 20'(pre_q) - 20'(post_q);
        end else begin
            pwr_a = 20'(pre_i);
            pwr_b = 20'(pre_q);
        end
    end

    assign acc_sum = acc_q + 45'(power_of(pwr_a, pwr_b));
    // average-and-decimate accumulator, dumped on each update
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            dec_cnt_q <= 12'h000;
            acc_q <= '0;
        end else if (clk_en) begin
            if (upd_ev) begin
                dec_cnt_q <= 12'h000;
                acc_q <= '0;
            end else if (in_fire) begin
                dec_cnt_q <= dec_cnt_q + 12'h001;
                acc_q <= acc_sum;
            end
        end
    end

    // rms in log2, request or clipping level, error term
    always_comb begin
        logic signed [ERR_W-1:0] l_sum;
        logic signed [ERR_W-1:0] l_n;
        l_sum = $signed({2'b00, log2_q8(acc_sum)});
        l_n = $signed({2'b00, log2_q8(45'(dec_cnt_q) + 45'h1)});
        rms_rel = ((l_sum - l_n) >>> 1) - RMS_FS_LOG;
        req_mag = 16'({desired_level[LVL_W-1:LVL_EXP_LSB], 8'h00})
            + 16'({desired_level[LVL_EXP_LSB-1:0], 2'b00});
        err_now = -$signed(req_mag) - rms_rel;
    end

    // loop gain choice and filter step
    always_comb begin
        logic signed [24:0] diff;
        logic signed [33:0] pp;
        logic signed [27:0] ke;
        logic signed [27:0] yt;
        abs_e1 = (e1_q < 0) ? -e1_q : e1_q;
        if ($unsigned(abs_e1) < {4'h0, error_threshold_level}) begin
            k_sel = loop_gain_near;
        end else begin
            k_sel = loop_gain_far;
        end
        diff = 25'(y1_q) - 25'(y2_q);
        pp = 34'(diff) * $signed(34'({1'b0, loop_pole_location}));
        ke = 28'(e1_q) * $signed(28'({1'b0, k_sel}));
        yt = 28'(y1_q) + 28'(pp >>> COEF_W) + ke;
        if (yt < 0) begin
            y_new = '0;
        end else if (yt > 28'(Y_MAX)) begin
            y_new = Y_MAX;
        end else begin
            y_new = yt[Y_W-1:0];
        end
    end

    // filter state and applied gain, loaded from the initial gain until the first update, then touched only on updates
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            started_q <= 1'b0;
            gain_q <= GAIN_RST;
            y1_q <= '0;
            y2_q <= '0;
            e1_q <= '0;
        end else if (clk_en) begin
            if (!started_q) begin
                gain_q <= initial_signal_gain;
                y1_q <= Y_W'({initial_signal_gain, 8'h00});
                y2_q <= Y_W'({initial_signal_gain, 8'h00});
                if (upd_ev) begin
                    started_q <= 1'b1;
                    e1_q <= err_now;
                end
            end else if (upd_ev) begin
                y2_q <= y1_q;
                y1_q <= y_new;
                gain_q <= y_new[19:8];
                e1_q <= err_now;
            end
        end
    end

    assign gain_word = gain_q;

    // two-entry buffer toward the receiver
    agc_word_if word_bus();
    assign word_bus.valid = in_fire;
    assign word_bus.data = {gain_q, post_i, post_q};
    assign in_ready = word_bus.ready;

    agc_out_buf #(.W(WORD_W)) u_buf (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .clk_en(clk_en),
        .wr(word_bus),
        .out_valid(out_valid),
        .out_ready(out_ready),
        .out_data(buf_data)
    );

    assign out_gain = buf_data[WORD_W-1:2*OUT_W];
    assign out_i = buf_data[2*OUT_W-1:OUT_W];
    assign out_q = buf_data[OUT_W-1:0];

    // checks
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);
    sequence s_pin_edge;
        clk_en && !chan_sync_sel && !sync_now && pin_rise;
    endsequence
    sequence s_sync_taken;
        hold_run_q && hold_cnt_q == $past(holdoff_count);
    endsequence
    property p_gain_hold;
        started_q && !upd_ev |=> $stable(gain_q);
    endproperty
    a_gain_hold: assert property (p_gain_hold)
        else $error("gain changed outside an update");
    property p_y_range;
        y1_q >= 0 && y1_q <= Y_MAX;
    endproperty
    a_y_range: assert property (p_y_range)
        else $error("loop state left its range");
    property p_sync_load;
        sync_req |=> s_sync_taken;
    endproperty
    a_sync_load: assert property (p_sync_load)
        else $error("sync did not load hold-off");
    property p_sync_dump;
        sync_fire && !sync_req |=> dec_cnt_q == 12'h000 && acc_q == '0
            && !hold_run_q;
    endproperty
    a_sync_dump: assert property (p_sync_dump)
        else $error("sync action did not dump");
    property p_period;
        period_end |=> dec_cnt_q == 12'h000 ##1 dec_cnt_q <= 12'h001;
    endproperty
    a_period: assert property (p_period)
        else $error("decimation period did not restart");
    // signed window around zero, written apart from the select logic
    property p_near;
        e1_q < $signed({4'h0, error_threshold_level})
            && e1_q > -$signed({4'h0, error_threshold_level})
            |-> k_sel == loop_gain_near;
    endproperty
    a_near: assert property (p_near)
        else $error("near gain not chosen");
    property p_sync_now;
        clk_en && sync_now |=> hold_run_q;
    endproperty
    a_sync_now: assert property (p_sync_now)
        else $error("sync now ignored");
    property p_pin_sync;
        s_pin_edge |=> s_sync_taken;
    endproperty
    a_pin_sync: assert property (p_pin_sync)
        else $error("pin sync not taken");
    property p_initial;
        !started_q && clk_en |=> gain_q == $past(initial_signal_gain);
    endproperty
    a_initial: assert property (p_initial)
        else $error("initial gain not applied");
endmodule

// ==== include/agc_pkg.sv ====
package agc_pkg;
    // data widths
    localparam int IN_W = 16;
    localparam int SCALED_W = 19;
    localparam int OUT_W = 16;
    localparam int GAIN_W = 12;
    localparam int COEF_W = 8;
    localparam int LVL_W = 8;
    localparam int HOLD_W = 16;
    localparam int DECIM_W = 12;
    localparam int ACC_W = 45;
    localparam int LOG_W = 14;
    localparam int Y_W = 24;
    localparam int ERR_W = 16;
    localparam int WORD_W = GAIN_W + 2 * OUT_W;

    // field positions of the gain and level words
    localparam int GAIN_EXP_LSB = 8;
    localparam int LVL_EXP_LSB = 6;

    // log domain: 8 fractional bits, one lsb is about 0.024 db
    localparam int LOG_FRAC = 8;
    localparam int LVL_MANT_SHIFT = 2;
    localparam int PWR_SHIFT = 4;
    localparam logic signed [ERR_W-1:0] RMS_FS_LOG = 16'sh0b00;

    // gain range and loop filter state range
    localparam logic [GAIN_W-1:0] GAIN_RST = 12'h000;
    localparam logic signed [Y_W-1:0] Y_MAX = 24'sh0fff00;

    // hold-off count at which the sync action fires
    localparam logic [HOLD_W-1:0] HOLD_FIRE = 16'h0001;

    // output width codes 0..7
    localparam logic [4:0] WIDTH_LUT [0:7] = '{
        5'h04, 5'h05, 5'h06, 5'h07, 5'h08, 5'h0a, 5'h0c, 5'h10
    };
endpackage

// ==== include/agc_word_if.sv ====
interface agc_word_if import agc_pkg::*; ();
    logic valid;
    logic ready;
    logic [WORD_W-1:0] data;
    // producer side
    modport src(output valid, output data, input ready);
    // buffer side
    modport snk(input valid, input data, output ready);
endinterface

// ==== logic/agc_out_buf.sv ====
module agc_out_buf import agc_pkg::*; #(
    parameter int W = WORD_W
) (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic clk_en,
    agc_word_if.snk wr,
    output logic out_valid,
    input wire logic out_ready,
    output logic [W-1:0] out_data
);
    logic hv_q;
    logic sv_q;
    logic hv_d;
    logic sv_d;
    logic [W-1:0] head_q;
    logic [W-1:0] spare_q;
    logic [W-1:0] head_d;
    logic [W-1:0] spare_d;
    logic push;
    logic pop;

    // handshakes on both sides
    assign push = wr.valid && wr.ready && clk_en;
    assign pop = hv_q && out_ready && clk_en;

    // head entry feeds the outputs, spare catches a word during a stall
    always_comb begin
        hv_d = hv_q;
        sv_d = sv_q;
        head_d = head_q;
        spare_d = spare_q;
        if (pop) begin
            if (sv_q) begin
                head_d = spare_q;
                sv_d = push;
                if (push) begin
                    spare_d = wr.data[W-1:0];
                end
            end else begin
                hv_d = push;
                if (push) begin
                    head_d = wr.data[W-1:0];
                end
            end
        end else if (push) begin
            if (!hv_q) begin
                hv_d = 1'b1;
                head_d = wr.data[W-1:0];
            end else begin
                sv_d = 1'b1;
                spare_d = wr.data[W-1:0];
            end
        end
    end

    // storage and registered ready
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            hv_q <= 1'b0;
            sv_q <= 1'b0;
            head_q <= '0;
            spare_q <= '0;
            wr.ready <= 1'b1;
        end else if (clk_en) begin
            hv_q <= hv_d;
            sv_q <= sv_d;
            head_q <= head_d;
            spare_q <= spare_d;
            wr.ready <= !(hv_d && sv_d);
        end
    end

    assign out_valid = hv_q;
    assign out_data = head_q;
endmodule

// ==== testbench/agc_sink_model.sv ====
// downstream receiver: takes words, optionally stalling at random
module agc_sink_model (
    input wire logic clk_sys,
    input wire logic [1:0] stall_mode,
    output logic out_ready
);
    timeunit 1ns;
    timeprecision 1ps;
    integer seed = 10;
    logic [31:0] r;
    initial out_ready = 1'b0;
    // mode 0 always ready, 1 random stalls, 2 fully stalled
    always @(negedge clk_sys) begin
        r = $random(seed);
        if (stall_mode == 2'h0)
            out_ready <= 1'b1;
        else if (stall_mode == 2'h1)
            out_ready <= r[0];
        else
            out_ready <= 1'b0;
    end
endmodule

// ==== testbench/tb_agc_loop_gain_and_sync.sv ====
module tb_agc_loop_gain_and_sync import agc_pkg::*; ;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_sys, rst_n, clk_en, in_valid, in_ready, out_valid, out_ready;
    logic chan_sync, sync_now, chan_sync_sel, clip_mode, track;
    logic signed [IN_W-1:0] in_i, in_q, a, b;
    logic [OUT_W-1:0] out_i, out_q;
    logic [GAIN_W-1:0] out_gain, gain_word, init_gain, thr, g0;
    logic [3:0] sync_pin;
    logic [1:0] sync_pin_sel, stall_mode;
    logic [2:0] width_sel;
    logic [COEF_W-1:0] k_near, k_far, pole;
    logic [LVL_W-1:0] level;
    logic [HOLD_W-1:0] holdoff;
    logic [DECIM_W-1:0] decim;
    logic [WORD_W-1:0] exp_q[$];
    logic [WORD_W-1:0] w;
    integer seed = 10;
    int err_total = 0;
    int n_checks = 0;
    int k;

    agc_loop_gain_and_sync dut (
        .clk_sys(clk_sys), .rst_n(rst_n), .clk_en(clk_en),
        .in_valid(in_valid), .in_ready(in_ready), .in_i(in_i), .in_q(in_q),
        .out_valid(out_valid), .out_ready(out_ready), .out_i(out_i),
        .out_q(out_q), .out_gain(out_gain), .gain_word(gain_word),
        .chan_sync(chan_sync), .sync_pin(sync_pin), .sync_now(sync_now),
        .chan_sync_sel(chan_sync_sel), .sync_pin_sel(sync_pin_sel),
        .clip_mode(clip_mode), .out_width_sel(width_sel),
        .loop_gain_near(k_near), .loop_gain_far(k_far),
        .loop_pole_location(pole), .error_threshold_level(thr),
        .initial_signal_gain(init_gain), .desired_level(level),
        .holdoff_count(holdoff), .update_decim(decim)
    );
    agc_sink_model sink (
        .clk_sys(clk_sys), .stall_mode(stall_mode), .out_ready(out_ready)
    );

    initial begin
        clk_sys = 1'b0;
        forever #4 clk_sys = ~clk_sys;
    end

    task automatic check(input logic [WORD_W-1:0] seen, exp_v);
        n_checks++;
        if (seen !== exp_v) begin
            err_total++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen,
                exp_v);
        end
    endtask

    task automatic print_verdict();
        if (err_total == 0 && n_checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    // scaled, truncated and saturated sample, left-justified
    function automatic logic [OUT_W-1:0] model_out(
        input logic signed [IN_W-1:0] x);
        logic signed [40:0] v;
        logic signed [40:0] lim;
        int sh;
        sh = 16 - int'(WIDTH_LUT[width_sel]);
        v = x;
        v = (v * (41'sh100 + $signed({33'h0, init_gain[7:0]}))) >>> 8;
        v = (v <<< init_gain[11:8]) >>> sh;
        lim = (41'sh1 <<< (15 - sh)) - 41'sh1;
        if (v > lim)
            v = lim;
        if (v < -lim - 41'sh1)
            v = -lim - 41'sh1;
        return OUT_W'(v <<< sh);
    endfunction

    // offer one sample and hold it until it is taken
    task automatic send(input logic signed [IN_W-1:0] x, y);
        int n;
        in_i = x;
        in_q = y;
        in_valid = 1'b1;
        for (n = 0; n < 64; n++) begin
            @(posedge clk_sys);
            if (in_ready === 1'b1)
                break;
        end
        if (n == 64) begin
            err_total++;
            print_verdict();
        end
        if (track)
            exp_q.push_back({init_gain, model_out(x), model_out(y)});
        @(negedge clk_sys);
    endtask

    task automatic zeros(input int n);
        repeat (n) send(16'sh0000, 16'sh0000);
        in_valid = 1'b0;
        @(negedge clk_sys);
    endtask

    task automatic drain();
        int n;
        in_valid = 1'b0;
        for (n = 0; n < 200 && exp_q.size() > 0; n++)
            @(negedge clk_sys);
        if (n == 200) begin
            err_total++;
            print_verdict();
        end
    endtask

    task automatic do_reset();
        exp_q.delete();
        rst_n = 1'b0;
        repeat (4) @(negedge clk_sys);
        check(WORD_W'({out_valid, in_ready}), WORD_W'(2'h1));
        rst_n = 1'b1;
        repeat (2) @(negedge clk_sys);
        check(WORD_W'(gain_word), WORD_W'(init_gain));
    endtask

    // sync source 0 software, 1 channel, 2..5 pins
    task automatic fire(input int src, input logic by_chan);
        chan_sync_sel = by_chan;
        sync_pin_sel = 2'(src - 2);
        if (src == 0)
            sync_now = 1'b1;
        else if (src == 1)
            chan_sync = 1'b1;
        else
            sync_pin[src-2] = 1'b1;
        @(negedge clk_sys);
        {sync_now, chan_sync} = 2'h0;
        repeat (6) @(negedge clk_sys);
        sync_pin = 4'h0;
    endtask

    // compare each taken output word with the oldest note
    always @(posedge clk_sys) begin
        if (rst_n === 1'b1 && out_valid === 1'b1 && out_ready === 1'b1
            && exp_q.size() > 0) begin
            w = exp_q.pop_front();
            check({out_gain, out_i, out_q}, w);
        end
    end

    initial begin
        {rst_n, in_valid, in_i, in_q, a, b} = '0;
        {chan_sync, sync_now, chan_sync_sel, clip_mode, sync_pin} = '0;
        {sync_pin_sel, stall_mode, k_near, k_far, pole, level} = '0;
        {clk_en, width_sel, thr, init_gain} = {1'b1, 3'h7, 12'hfff, 12'h0};
        {holdoff, decim, track} = {16'h0005, 12'hfff, 1'b1};
        // every width code with three gains, random stalls
        for (int s = 0; s < 8; s++) begin
            for (int gi = 0; gi < 3; gi++) begin
                width_sel = 3'(s);
                init_gain = gi == 0 ? 12'h000 : gi == 1 ? 12'h100 : 12'h280;
                do_reset();
                stall_mode = 2'h1;
                for (int n = 0; n < 6; n++) begin
                    a = n == 0 ? 16'sh7fff : 16'($random(seed));
                    b = n == 0 ? 16'sh8000 : 16'($random(seed));
                    if (gi == 2)
                        {a[7:0], b[7:0]} = 16'h0;
                    send(a, b);
                end
                drain();
            end
        end
        // stalled receiver: two words held, none lost
        stall_mode = 2'h2;
        // let the receiver settle into its stall before offering words
        @(negedge clk_sys);
        in_valid = 1'b1;
        k = 0;
        repeat (8) begin
            @(posedge clk_sys);
            if (in_ready === 1'b1) begin
                k++;
                exp_q.push_back({init_gain, model_out(in_i), model_out(in_q)});
            end
            @(negedge clk_sys);
        end
        check(WORD_W'(k), WORD_W'(4'h2));
        stall_mode = 2'h0;
        drain();
        // near gain below threshold, far gain and saturation above
        track = 1'b0;
        {k_far, pole, decim, init_gain} = {8'h40, 8'h80, 12'h003, 12'h400};
        for (int m = 0; m < 2; m++) begin
            clip_mode = m[0];
            thr = 12'hfff;
            do_reset();
            zeros(40);
            check(WORD_W'(gain_word), WORD_W'(12'h400));
            thr = 12'h000;
            zeros(300);
            check(WORD_W'(gain_word), WORD_W'(12'hfff));
        end
        // each sync source; gain held until the hold-off runs out
        {k_far, pole, decim, thr} = {8'h08, 8'h00, 12'hfff, 12'h000};
        clip_mode = 1'b0;
        do_reset();
        fire(0, 1'b0);
        zeros(5);
        for (int src = 0; src < 7; src++) begin
            g0 = gain_word;
            fire(src == 6 ? 1 : src, src == 1);
            zeros(4);
            check(WORD_W'(gain_word), WORD_W'(g0));
            zeros(1);
            repeat (3) @(negedge clk_sys);
            check(WORD_W'(gain_word !== g0), WORD_W'(src != 6));
        end
        print_verdict();
    end
endmodule
